/* File: logic/osc_clock_defines.vh */
`ifndef OSC_CLOCK_DEFINES_VH
`define OSC_CLOCK_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_OSC_CTRL 6'h00
`define OFS_CLK_DIV 6'h04
`define OFS_PLL_FBD 6'h08
`define OFS_UNLOCK 6'h0C
`define OFS_AUX_REF 6'h10

// ----------------------------------------------------------------------
// Oscillator control field positions
// ----------------------------------------------------------------------
`define OSC_CUR_LSB 12
`define OSC_NXT_LSB 8
`define OSC_SRC_LOCK 7
`define OSC_PIN_LOCK 6
`define OSC_PLL_LOCK 5
`define OSC_FAIL 3
`define OSC_SWITCH 0

// ----------------------------------------------------------------------
// Clock divisor field positions and reset values
// ----------------------------------------------------------------------
`define DIV_ROI 15
`define DIV_DOZE_LSB 12
`define DIV_REDUCE_ENABLE 11
`define DIV_RC_LSB 8
`define DIV_POST_LSB 6
`define DIV_PRE_LSB 0
`define RST_DOZE 3'h3
`define RST_RC_POST 3'h0
`define RST_VCO_POST 2'h1
`define RST_PRE 5'h00
`define RST_FBD 9'h030

// ----------------------------------------------------------------------
// Auxiliary and reference control field positions
// ----------------------------------------------------------------------
`define AUX_FAST_RC 0
`define REF_ON 15
`define REF_SRC 12
`define REF_DIV_LSB 8

// ----------------------------------------------------------------------
// Source codes, unlock keys, constants
// ----------------------------------------------------------------------
`define SRC_FRC 3'h0
`define SRC_FRC_PLL 3'h1
`define SRC_PRI 3'h2
`define SRC_PRI_PLL 3'h3
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA
`define CFG_SW_NO_MON 2'h1
`define CFG_SW_MON 2'h0
`define AUX_MULT 5'h10
`define SWITCH_CYCLES 8
`define LOCK_CYCLES 32
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: logic/oscillator_clock_control.v */
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
// Function
// [R1] Auxiliary PLL multiplies reference by fixed sixteen.
// [R2] Auxiliary PLL reference: primary or fast RC.
// [R3] Software sets auxiliary clock 120 MHz.
// [R4] Main PLL at most 30 MIPS then.
// [R5] Reference output scales system clock or crystal.
// [R6] Current source field reports active source.
// [R7] Next source field loads configuration at reset.
// [R8] Oscillator control writes need unlock sequence.
// [R9] Source lock bit blocks switching in 01.
// [R10] Pin map lock rejects mapping register writes.
// [R11] PLL lock flag shows lock or timer.
// [R12] Clock fail flag sticky until software clears.
// [R13] Switch request starts switch, clears when done.
// [R14] Software passes through fast RC between PLLs.
// [R15] Interrupt clears reduce enable when recover set.
// [R16] Reduction field divides by power of two.
// [R17] Reduce enable clear forces ratio one.
// [R18] Fast RC postscaler divides, 111 is 256.
// [R19] VCO postscaler divides two, four, eight.
// [R20] PLL prescaler divides by field plus two.
// [R21] Feedback divisor multiplies by field plus two.
// [R22] Unimplemented bits ignore writes, read zero.
// [R23] Switching disabled holds request at zero.
// [R24] Redundant switch request clears itself, aborts.
// [R25] Valid switch start clears lock and fail.
// [R26] Current source updated before request clears.
`include "osc_clock_defines.vh"

module oscillator_clock_control #(
    parameter SWITCH_CYCLES = `SWITCH_CYCLES,
    parameter LOCK_CYCLES = `LOCK_CYCLES
) (
    input wire aclk,
    input wire aresetn,
    input wire [5:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [5:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [2:0] cfg_initial_source,
    input wire [1:0] switch_monitor_cfg,
    input wire pll_locked,
    input wire interrupt_event,
    input wire clock_fail_detect,
    input wire crystal_clock,
    output wire [2:0] current_source_sel,
    output wire switch_busy,
    output wire pin_map_lock,
    output wire pin_map_write_allow,
    output wire pll_lock_flag,
    output wire [2:0] cpu_clock_div_log2,
    output wire [3:0] rc_div_log2,
    output wire [3:0] vco_post_div,
    output wire [5:0] pll_prescale_div,
    output wire [9:0] pll_feedback_mult,
    output wire [4:0] aux_pll_mult,
    output wire aux_ref_fast_rc,
    output wire ref_clk_out,
    output wire ref_clk_oe
);

// ----------------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------------
localparam ST_IDLE = 2'h0;
localparam ST_RUN = 2'h1;
localparam ST_DONE = 2'h2;

reg aw_full_ff, w_full_ff, bvalid_ff, rvalid_ff;
reg [5:0] awaddr_ff;
reg [15:0] wdata_ff;
reg [1:0] wstrb_ff;
reg [1:0] bresp_ff, rresp_ff;
reg [15:0] rdata_ff;
reg [1:0] key_ff;
reg init_ff;
reg [2:0] cur_src_ff, nxt_src_ff;
reg src_lock_ff, pin_lock_ff, fail_ff, req_ff, lock_ff, lost_ff;
reg roi_ff, reduce_enable_ff;
reg [2:0] doze_ff, rc_post_ff;
reg [1:0] vco_post_ff;
reg [4:0] pre_ff;
reg [8:0] fbd_ff;
reg aux_fast_ff, ref_on_ff, ref_src_ff;
reg [3:0] ref_div_ff;
reg [1:0] state_ff;
reg [7:0] sw_cnt_ff;
reg [7:0] lock_cnt_ff;
reg pll_locked_d_ff;
reg [1:0] s1_ff, s2_ff, s3_ff, filt_ff, filt_d_ff;
reg [14:0] ref_cnt_ff;
reg ref_out_ff;
reg [2:0] cpu_div_ff;
reg [3:0] rc_div_ff, vco_div_ff;
reg [5:0] n1_ff;
reg [9:0] m_ff;

wire wr_go = aw_full_ff & w_full_ff & ~bvalid_ff;
wire rd_go = s_axi_arvalid & ~rvalid_ff;
wire hit_osc = awaddr_ff[5:2] == `OFS_OSC_CTRL >> 2;
wire hit_div = awaddr_ff[5:2] == `OFS_CLK_DIV >> 2;
wire hit_fbd = awaddr_ff[5:2] == `OFS_PLL_FBD >> 2;
wire hit_key = awaddr_ff[5:2] == `OFS_UNLOCK >> 2;
wire hit_aux = awaddr_ff[5:2] == `OFS_AUX_REF >> 2;
wire wr_ok = hit_osc | hit_div | hit_fbd | hit_key | hit_aux;
wire osc_wr = wr_go & hit_osc & (key_ff == 2'h2); // see [R8]
wire lo_wr = wstrb_ff[0];
wire hi_wr = wstrb_ff[1];
wire sw_en = ~switch_monitor_cfg[1];
wire mon_en = switch_monitor_cfg == `CFG_SW_MON;
wire sw_blocked = (switch_monitor_cfg == `CFG_SW_NO_MON) & src_lock_ff;
wire pll_mode = (cur_src_ff == `SRC_FRC_PLL) | (cur_src_ff == `SRC_PRI_PLL);
wire sw_start = (state_ff == ST_IDLE) & req_ff & ~init_ff &
    (nxt_src_ff != cur_src_ff);
wire lock_done = lock_cnt_ff == LOCK_CYCLES[7:0];
wire fail_evt = filt_ff[0] & ~filt_d_ff[0];
wire xtal_rise = filt_ff[1] & ~filt_d_ff[1];
wire ref_tick = ref_src_ff ? xtal_rise : 1'b1;
wire [3:0] ref_idx = ref_div_ff - 4'h1;
wire [14:0] ref_cnt_nxt = ref_cnt_ff + 15'h0001;
wire ref_stop = wr_go & hit_aux & hi_wr & ~wdata_ff[`REF_ON];

// ----------------------------------------------------------------------
// Bus slave
// ----------------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_full_ff <= 1'b0;
        w_full_ff <= 1'b0;
        bvalid_ff <= 1'b0;
        rvalid_ff <= 1'b0;
        awaddr_ff <= 6'h00;
        wdata_ff <= 16'h0000;
        wstrb_ff <= 2'h0;
        bresp_ff <= 2'h0;
        rresp_ff <= 2'h0;
        rdata_ff <= 16'h0000;
    end else begin
        if (s_axi_awvalid && !aw_full_ff) begin
            aw_full_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_full_ff) begin
            w_full_ff <= 1'b1;
            wdata_ff <= s_axi_wdata[15:0];
            wstrb_ff <= s_axi_wstrb[1:0];
        end
        if (wr_go) begin
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
        if (rd_go) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= `RESP_OKAY;
            // Unused and reserved positions are left as zero.
            case (s_axi_araddr[5:2]) // see [R22]
                `OFS_OSC_CTRL >> 2: begin
                    rdata_ff <= {1'b0, cur_src_ff, 1'b0, nxt_src_ff,
                        src_lock_ff, pin_lock_ff, lock_ff, 1'b0,
                        fail_ff, 2'h0, req_ff}; // see [R6]
                end
                `OFS_CLK_DIV >> 2: begin
                    rdata_ff <= {roi_ff, doze_ff, reduce_enable_ff, rc_post_ff,
                        vco_post_ff, 1'b0, pre_ff};
                end
                `OFS_PLL_FBD >> 2: begin
                    rdata_ff <= {7'h00, fbd_ff};
                end
                `OFS_UNLOCK >> 2: begin
                    rdata_ff <= {14'h0000, key_ff};
                end
                `OFS_AUX_REF >> 2: begin
                    rdata_ff <= {ref_on_ff, 2'h0, ref_src_ff, ref_div_ff,
                        7'h00, aux_fast_ff};
                end
                default: begin
                    rdata_ff <= 16'h0000;
                    rresp_ff <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------------
// Unlock sequence
// ----------------------------------------------------------------------
// Any write to the oscillator control word uses up the unlock, so each
// such write needs its own key pair.
always @(posedge aclk) begin
    if (!aresetn) begin
        key_ff <= 2'h0;
    end else if (wr_go && hit_key && lo_wr) begin
        if (wdata_ff[7:0] == `KEY_FIRST) begin
            key_ff <= 2'h1;
        end else if (key_ff == 2'h1 && wdata_ff[7:0] == `KEY_SECOND) begin
            key_ff <= 2'h2; // see [R8]
        end else begin
            key_ff <= 2'h0;
        end
    end else if (wr_go && hit_osc) begin
        key_ff <= 2'h0; // see [R8]
    end
end

// ----------------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        s1_ff <= 2'h0;
        s2_ff <= 2'h0;
        s3_ff <= 2'h0;
        filt_ff <= 2'h0;
        filt_d_ff <= 2'h0;
    end else begin
        s1_ff <= {crystal_clock, clock_fail_detect};
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        if (s2_ff[0] == s3_ff[0]) begin
            filt_ff[0] <= s3_ff[0];
        end
        if (s2_ff[1] == s3_ff[1]) begin
            filt_ff[1] <= s3_ff[1];
        end
        filt_d_ff <= filt_ff;
    end
end

// ----------------------------------------------------------------------
// Oscillator control and switch sequence
// ----------------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        init_ff <= 1'b1;
        cur_src_ff <= 3'h0;
        nxt_src_ff <= 3'h0;
        src_lock_ff <= 1'b0;
        pin_lock_ff <= 1'b0;
        fail_ff <= 1'b0;
        req_ff <= 1'b0;
        state_ff <= ST_IDLE;
        sw_cnt_ff <= 8'h00;
    end else begin
        // The strap is caught one edge after release, not under reset.
        if (init_ff) begin
            init_ff <= 1'b0;
            cur_src_ff <= cfg_initial_source; // see [R7]
            nxt_src_ff <= cfg_initial_source; // see [R7]
        end else if (osc_wr && hi_wr) begin
            nxt_src_ff <= wdata_ff[`OSC_NXT_LSB +: 3];
        end
        if (osc_wr && lo_wr) begin
            src_lock_ff <= wdata_ff[`OSC_SRC_LOCK];
            pin_lock_ff <= wdata_ff[`OSC_PIN_LOCK]; // see [R10]
        end
        // A failure in the clear cycle still sets the flag.
        if (fail_evt && mon_en) begin
            fail_ff <= 1'b1; // see [R12]
        end else if (sw_start) begin
            fail_ff <= 1'b0; // see [R25]
        end else if (osc_wr && lo_wr && !wdata_ff[`OSC_FAIL]) begin
            fail_ff <= 1'b0; // see [R12]
        end
        case (state_ff)
            ST_IDLE: begin
                sw_cnt_ff <= 8'h00;
                if (!sw_en) begin
                    req_ff <= 1'b0; // see [R23]
                end else if (req_ff && !init_ff) begin
                    if (nxt_src_ff == cur_src_ff) begin
                        req_ff <= 1'b0; // see [R24]
                    end else begin
                        state_ff <= ST_RUN; // see [R13]
                    end
                end else if (osc_wr && lo_wr && wdata_ff[`OSC_SWITCH] &&
                    !sw_blocked) begin
                    req_ff <= 1'b1; // see [R9] and [R13]
                end
            end
            ST_RUN: begin
                sw_cnt_ff <= sw_cnt_ff + 8'h01;
                if (sw_cnt_ff == SWITCH_CYCLES[7:0] - 8'h01) begin
                    cur_src_ff <= nxt_src_ff; // see [R26]
                    state_ff <= ST_DONE;
                end
            end
            ST_DONE: begin
                req_ff <= 1'b0; // see [R13] and [R26]
                state_ff <= ST_IDLE;
            end
            default: begin
                state_ff <= ST_IDLE;
            end
        endcase
    end
end

// ----------------------------------------------------------------------
// PLL lock flag
// ----------------------------------------------------------------------
// The start-up timer only stands in until the PLL has been seen to lock;
// a later loss of lock drops the flag even after the timer ran out.
always @(posedge aclk) begin
    if (!aresetn) begin
        lock_cnt_ff <= 8'h00;
        lock_ff <= 1'b0;
        lost_ff <= 1'b0;
        pll_locked_d_ff <= 1'b0;
    end else begin
        pll_locked_d_ff <= pll_locked;
        if (sw_start || !pll_mode || state_ff != ST_IDLE) begin
            lock_cnt_ff <= 8'h00;
        end else if (!lock_done) begin
            lock_cnt_ff <= lock_cnt_ff + 8'h01;
        end
        if (sw_start) begin
            lost_ff <= 1'b0; // see [R25]
        end else if (pll_locked_d_ff && !pll_locked) begin
            lost_ff <= 1'b1;
        end
        lock_ff <= pll_mode && state_ff == ST_IDLE && !sw_start &&
            (pll_locked || (lock_done && !lost_ff)); // see [R11] and [R25]
    end
end

// ----------------------------------------------------------------------
// Clock divisor, feedback divisor, auxiliary and reference control
// ----------------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        roi_ff <= 1'b0;
        reduce_enable_ff <= 1'b0;
        doze_ff <= `RST_DOZE; // see [R16]
        rc_post_ff <= `RST_RC_POST; // see [R18]
        vco_post_ff <= `RST_VCO_POST; // see [R19]
        pre_ff <= `RST_PRE; // see [R20]
        fbd_ff <= `RST_FBD; // see [R21]
        aux_fast_ff <= 1'b0;
        ref_on_ff <= 1'b0;
        ref_src_ff <= 1'b0;
        ref_div_ff <= 4'h0;
    end else begin
        if (wr_go && hit_div && hi_wr) begin
            roi_ff <= wdata_ff[`DIV_ROI];
            doze_ff <= wdata_ff[`DIV_DOZE_LSB +: 3];
            rc_post_ff <= wdata_ff[`DIV_RC_LSB +: 3];
        end
        // An interrupt outranks a software write of the enable bit.
        if (interrupt_event && roi_ff) begin
            reduce_enable_ff <= 1'b0; // see [R15]
        end else if (wr_go && hit_div && hi_wr) begin
            reduce_enable_ff <= wdata_ff[`DIV_REDUCE_ENABLE];
        end
        if (wr_go && hit_div && lo_wr) begin
            vco_post_ff <= wdata_ff[`DIV_POST_LSB +: 2];
            pre_ff <= wdata_ff[`DIV_PRE_LSB +: 5];
        end
        if (wr_go && hit_fbd && lo_wr) begin
            fbd_ff[7:0] <= wdata_ff[7:0];
        end
        if (wr_go && hit_fbd && hi_wr) begin
            fbd_ff[8] <= wdata_ff[8];
        end
        if (wr_go && hit_aux && lo_wr) begin
            aux_fast_ff <= wdata_ff[`AUX_FAST_RC]; // see [R2]
        end
        if (wr_go && hit_aux && hi_wr) begin
            ref_on_ff <= wdata_ff[`REF_ON];
            ref_src_ff <= wdata_ff[`REF_SRC];
            ref_div_ff <= wdata_ff[`REF_DIV_LSB +: 4];
        end
    end
end

// ----------------------------------------------------------------------
// Derived divider settings
// ----------------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        cpu_div_ff <= 3'h0;
        rc_div_ff <= 4'h0;
        vco_div_ff <= 4'h4;
        n1_ff <= 6'h02;
        m_ff <= 10'h032;
    end else begin
        cpu_div_ff <= reduce_enable_ff ? doze_ff : 3'h0; // see [R16] and [R17]
        rc_div_ff <= (rc_post_ff == 3'h7) ? 4'h8 : {1'b0, rc_post_ff};
        case (vco_post_ff) // see [R19]
            2'h0: vco_div_ff <= 4'h2;
            2'h1: vco_div_ff <= 4'h4;
            2'h3: vco_div_ff <= 4'h8;
            default: vco_div_ff <= 4'h0;
        endcase
        n1_ff <= {1'b0, pre_ff} + 6'h02; // see [R20]
        m_ff <= {1'b0, fbd_ff} + 10'h002; // see [R21]
    end
end

// ----------------------------------------------------------------------
// Reference clock output
// ----------------------------------------------------------------------
// The system clock cannot leave a flop undivided, so code zero on the
// system source gives half the system rate.
always @(posedge aclk) begin
    if (!aresetn) begin
        ref_cnt_ff <= 15'h0000;
        ref_out_ff <= 1'b0;
    end else if (!ref_on_ff || ref_stop) begin
        // Dropping the pin with its enable avoids a stray high level.
        ref_cnt_ff <= 15'h0000;
        ref_out_ff <= 1'b0;
    end else begin
        if (ref_tick) begin
            ref_cnt_ff <= ref_cnt_nxt;
        end
        if (ref_div_ff == 4'h0) begin
            ref_out_ff <= ref_src_ff ? filt_ff[1] : ~ref_out_ff; // see [R5]
        end else begin
            ref_out_ff <= ref_cnt_ff[ref_idx]; // see [R5]
        end
    end
end

// ----------------------------------------------------------------------
// Outputs
// ----------------------------------------------------------------------
assign s_axi_awready = ~aw_full_ff;
assign s_axi_wready = ~w_full_ff;
assign s_axi_bvalid = bvalid_ff;
assign s_axi_bresp = bresp_ff;
assign s_axi_arready = ~rvalid_ff;
assign s_axi_rvalid = rvalid_ff;
assign s_axi_rresp = rresp_ff;
assign s_axi_rdata = {16'h0000, rdata_ff};
assign current_source_sel = cur_src_ff;
assign switch_busy = state_ff != ST_IDLE;
assign pin_map_lock = pin_lock_ff;
assign pin_map_write_allow = ~pin_lock_ff; // see [R10]
assign pll_lock_flag = lock_ff;
assign cpu_clock_div_log2 = cpu_div_ff;
assign rc_div_log2 = rc_div_ff; // see [R18]
assign vco_post_div = vco_div_ff;
assign pll_prescale_div = n1_ff;
assign pll_feedback_mult = m_ff;
assign aux_pll_mult = `AUX_MULT; // see [R1]
assign aux_ref_fast_rc = aux_fast_ff; // see [R2]
assign ref_clk_out = ref_out_ff;
assign ref_clk_oe = ref_on_ff;

endmodule // oscillator_clock_control

/* File: verification/osc_clock_monitor.sv */
`timescale 1ns/100ps
module osc_clock_monitor #(
    parameter SWITCH_CYCLES = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [1:0] switch_monitor_cfg,
    input wire [2:0] current_source_sel,
    input wire switch_busy,
    input wire pin_map_lock,
    input wire pin_map_write_allow,
    input wire pll_lock_flag,
    input wire [3:0] rc_div_log2,
    input wire [3:0] vco_post_div,
    input wire [4:0] aux_pll_mult,
    input wire ref_clk_out,
    input wire ref_clk_oe
);
// ----------------------------------------------------------------------
// Helper logic and properties
// ----------------------------------------------------------------------
// The source loads its strap just after reset, so watch it only later.
localparam int SW_MAX = SWITCH_CYCLES + 4;
reg [1:0] up_ff;
always @(posedge aclk) begin
    if (!aresetn)
        up_ff <= 2'h0;
    else if (up_ff != 2'h3)
        up_ff <= up_ff + 2'h1;
end
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
property p_aux; aux_pll_mult == 5'h10; endproperty
a_aux: assert property (p_aux)
    else $error("aux multiplier wrong");
property p_pin; pin_map_write_allow == !pin_map_lock; endproperty
a_pin: assert property (p_pin)
    else $error("pin map permission wrong");
property p_vco; vco_post_div inside {4'h0, 4'h2, 4'h4, 4'h8}; endproperty
a_vco: assert property (p_vco)
    else $error("vco divisor illegal");
property p_rc; rc_div_log2 <= 4'h8 && rc_div_log2 != 4'h7; endproperty
a_rc: assert property (p_rc)
    else $error("rc divisor illegal");
property p_dis; switch_monitor_cfg[1] |-> !switch_busy; endproperty
a_dis: assert property (p_dis)
    else $error("switch while disabled");
property p_src;
    up_ff == 2'h3 && $changed(current_source_sel) |-> $past(switch_busy);
endproperty
a_src: assert property (p_src)
    else $error("source changed outside switch");
property p_lock;
    switch_busy && $past(switch_busy) |-> !pll_lock_flag;
endproperty
a_lock: assert property (p_lock)
    else $error("lock flag during switch");
property p_ref; !ref_clk_oe |-> !ref_clk_out; endproperty
a_ref: assert property (p_ref)
    else $error("reference out while off");
property p_sw; $rose(switch_busy) |-> ##[1:SW_MAX] !switch_busy; endproperty
a_sw: assert property (p_sw)
    else $error("switch never completed");
c_sw: cover property ($rose(switch_busy));
c_lock: cover property ($rose(pll_lock_flag));
c_ref: cover property (ref_clk_oe && ref_clk_out);
endmodule // osc_clock_monitor

/* File: verification/oscillator_clock_control_bench.sv */
`timescale 1ns/100ps
module oscillator_clock_control_bench;
// ----------------------------------------------------------------------
// Signals, bus tasks and scenarios
// ----------------------------------------------------------------------
reg aclk = 1'h0;
reg aresetn = 1'h0;
reg [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
reg [31:0] s_axi_wdata = 32'h0;
reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
reg [2:0] cfg_initial_source = 3'h2;
reg [1:0] switch_monitor_cfg = 2'h1;
reg pll_locked = 1'h1, interrupt_event = 1'h0, clock_fail_detect = 1'h0;
wire [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
wire [3:0] s_axi_wstrb = 4'hF;
wire crystal_clock = 1'h0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire [2:0] current_source_sel, cpu_clock_div_log2;
wire switch_busy, pin_map_lock, pin_map_write_allow, pll_lock_flag;
wire aux_ref_fast_rc, ref_clk_out, ref_clk_oe;
wire [3:0] rc_div_log2, vco_post_div;
wire [5:0] pll_prescale_div;
wire [9:0] pll_feedback_mult;
wire [4:0] aux_pll_mult;
integer bad_count = 0, checks = 0, i;
reg [31:0] r, d;
reg [1:0] resp;
reg p;
oscillator_clock_control dut (.*);
task chk(input [31:0] g, input [31:0] e);
    begin
        checks = checks + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    end
endtask
task finish_test;
    begin
        if (bad_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
endtask
task wr(input [5:0] a, input [31:0] v);
    begin
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        resp = s_axi_bresp;
    end
endtask
task rd(input [5:0] a);
    begin
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        r = s_axi_rdata;
        resp = s_axi_rresp;
    end
endtask
task rchk(input [5:0] a, input [31:0] e);
    begin
        rd(a);
        chk(r, e);
    end
endtask
// The oscillator control register only takes a write once the key pair has armed it.
task uw(input [31:0] v);
    begin
        wr(6'h0C, 32'h55);
        wr(6'h0C, 32'hAA);
        wr(6'h00, v);
    end
endtask
task settle;
    begin
        repeat (3) @(posedge aclk);
        #1;
    end
endtask
task wait_idle;
    begin
        for (i = 0; i < 40 && (i < 3 || switch_busy); i = i + 1)
            @(posedge aclk);
        settle;
    end
endtask
task do_reset(input [1:0] m);
    begin
        @(posedge aclk);
        aresetn <= 1'h0;
        switch_monitor_cfg <= m;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
    end
endtask
task pulse_irq;
    begin
        @(posedge aclk);
        interrupt_event <= 1'h1;
        @(posedge aclk);
        interrupt_event <= 1'h0;
        settle;
    end
endtask
task t_reset;
    begin
        rchk(6'h00, 32'h2200);
        rchk(6'h04, 32'h3040);
        rchk(6'h08, 32'h0030);
        chk(pll_feedback_mult, 10'h032);
        wr(6'h3C, 32'h1);
        chk(resp, 2'h2);
        rd(6'h3C);
        chk(resp, 2'h2);
    end
endtask
task t_lock;
    begin
        wr(6'h00, 32'h0240);
        rchk(6'h00, 32'h2200);
        uw(32'h0240);
        rchk(6'h00, 32'h2240);
        chk(pin_map_write_allow, 1'h0);
        uw(32'h0201);
        settle;
        rchk(6'h00, 32'h2200);
        uw(32'h0301);
        wait_idle;
        rchk(6'h00, 32'h3320);
        pll_locked <= 1'h0;
        settle;
        rchk(6'h00, 32'h3300);
        pll_locked <= 1'h1;
        uw(32'h0380);
        uw(32'h0081);
        settle;
        chk(current_source_sel, 3'h3);
        uw(32'h0000);
        uw(32'h0001);
        wait_idle;
        rchk(6'h00, 32'h0000);
    end
endtask
task t_fail;
    begin
        do_reset(2'h0);
        clock_fail_detect <= 1'h1;
        repeat (8) @(posedge aclk);
        clock_fail_detect <= 1'h0;
        repeat (8) @(posedge aclk);
        rchk(6'h00, 32'h2208);
        uw(32'h0200);
        rchk(6'h00, 32'h2200);
    end
endtask
task t_div;
    begin
        wr(6'h04, 32'hD840);
        settle;
        chk(cpu_clock_div_log2, 3'h5);
        pulse_irq;
        chk(cpu_clock_div_log2, 3'h0);
        rchk(6'h04, 32'hD040);
        wr(6'h04, 32'h5840);
        pulse_irq;
        rchk(6'h04, 32'h5840);
        for (i = 0; i < 8; i = i + 1) begin
            d = (i << 8) | ((i & 3) << 6) | i;
            wr(6'h04, d);
            settle;
            chk(rc_div_log2, i == 7 ? 8 : i);
            d = (i & 3) == 3 ? 8 : (i & 3) == 2 ? 0 : 2 << (i & 3);
            chk(vco_post_div, d);
            chk(pll_prescale_div, i + 2);
            chk(cpu_clock_div_log2, 3'h0);
        end
        wr(6'h04, 32'hFFFFFFFF);
        rchk(6'h04, 32'hFFDF);
        chk(cpu_clock_div_log2, 3'h7);
        chk(pll_prescale_div, 6'h21);
        wr(6'h08, 32'hFFFFFFFF);
        rchk(6'h08, 32'h01FF);
        chk(pll_feedback_mult, 10'h201);
    end
endtask
task t_ref;
    begin
        wr(6'h10, 32'h8001);
        settle;
        chk(aux_ref_fast_rc, 1'h1);
        chk(ref_clk_oe, 1'h1);
        p = ref_clk_out;
        repeat (4) begin
            @(posedge aclk);
            #1;
            chk(ref_clk_out, !p);
            p = ref_clk_out;
        end
        wr(6'h10, 32'h0);
        settle;
        chk(aux_ref_fast_rc, 1'h0);
        chk(ref_clk_oe, 1'h0);
    end
endtask
task t_off;
    begin
        do_reset(2'h2);
        uw(32'h0001);
        settle;
        rd(6'h00);
        chk(r & 32'h7001, 32'h2000);
    end
endtask
initial begin
    forever #10 aclk = ~aclk;
end
initial begin
    repeat (20000) @(posedge aclk);
    bad_count = bad_count + 1;
    finish_test;
end
initial begin
    do_reset(2'h1);
    t_reset;
    t_lock;
    t_div;
    t_ref;
    t_fail;
    t_off;
    finish_test;
end
endmodule // oscillator_clock_control_bench
bind oscillator_clock_control osc_clock_monitor #(
    .SWITCH_CYCLES(SWITCH_CYCLES)
) mon (.*);
